// file: shared/rsocr_pkg.sv
package rsocr_pkg;
   localparam int WORD_W  = 16;
   localparam int BYTE_W  = 8;
   localparam int ADDR_W  = 6;
   localparam int IDX_W   = 5;
   localparam int DEPTH   = 32;
   localparam int RATE_W  = 14;
   localparam int ANA_W   = 12;
   localparam int DECIM_W = 4;

   // ----------------------------------------------------------------
   // Byte addresses
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] A_SUPPLY   = 6'h02;
   localparam logic [ADDR_W-1:0] A_RATE     = 6'h04;
   localparam logic [ADDR_W-1:0] A_RATE_EXT = 6'h06;
   localparam logic [ADDR_W-1:0] A_AUX      = 6'h0A;
   localparam logic [ADDR_W-1:0] A_TEMP     = 6'h0C;
   localparam logic [ADDR_W-1:0] A_DECIM    = 6'h36;
   localparam logic [ADDR_W-1:0] A_RANGE    = 6'h38;
   localparam logic [ADDR_W-1:0] A_DIAG     = 6'h3C;
   localparam logic [ADDR_W-1:0] A_CMD      = 6'h3E;

   // ----------------------------------------------------------------
   // Fields and masks
   // ----------------------------------------------------------------
   localparam int B_NEW    = 15;
   localparam int B_ERR    = 14;
   localparam int B_WRITE  = 15;
   localparam int CMD_FLASH = 3;
   localparam logic [BYTE_W-1:0] CMD_IMPL_MASK   = 8'h08;
   localparam logic [DEPTH-1:0]  FLASH_MIRROR    = 32'h3C1F0C01;
   localparam logic [DEPTH-1:0]  WRITABLE        = 32'h3F1F0C00;
   localparam logic [WORD_W-1:0] DEF_SCALE       = 16'h0800;
   localparam logic [WORD_W-1:0] DEF_MISC        = 16'h0006;
   localparam logic [WORD_W-1:0] DEF_DECIM       = 16'h0000;
   localparam logic [WORD_W-1:0] DEF_RANGE       = 16'h0401;
   localparam logic [WORD_W-1:0] FULL_MASK       = 16'hFFFF;
   localparam int IDX_SCALE = 11;
   localparam int IDX_MISC  = 26;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 40;
   localparam int FLASH_BACKUP_MS = 40;
   localparam int FLASH_BACKUP_CYCLES =
      FLASH_BACKUP_MS * 1000000 / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      SEQ_RESTORE = 2'b00,
      SEQ_IDLE    = 2'b01,
      SEQ_BACKUP  = 2'b10,
      SEQ_SETTLE  = 2'b11
   } rsocr_seq_e;

   typedef struct packed {
      logic              valid;
      logic [RATE_W-1:0] rate;
      logic [WORD_W-1:0] rate_ext;
      logic [ANA_W-1:0]  temp;
      logic [ANA_W-1:0]  supply;
      logic [ANA_W-1:0]  aux;
   } rsocr_sample_s;

   typedef struct packed {
      logic [DECIM_W-1:0] decimation;
      logic [2:0]         range_sel;
      logic [2:0]         filter_taps;
   } rsocr_dsp_cfg_s;

   typedef logic [DEPTH*WORD_W-1:0] rsocr_image_t;

   function automatic rsocr_image_t cfg_defaults();
      rsocr_image_t img;
      img = '0;
      img[IDX_SCALE*WORD_W +: WORD_W]        = DEF_SCALE;
      img[IDX_MISC*WORD_W +: WORD_W]         = DEF_MISC;
      img[int'(A_DECIM[5:1])*WORD_W +: WORD_W] = DEF_DECIM;
      img[int'(A_RANGE[5:1])*WORD_W +: WORD_W] = DEF_RANGE;
      return img;
   endfunction : cfg_defaults
endpackage : rsocr_pkg

// file: verilog/rsocr_cfg_mem.sv
`timescale 1ns/1ps
module rsocr_cfg_mem #(
   parameter int                         WIDTH = 16,
   parameter int                         DEPTH = 32,
   parameter int                         AW    = 5,
   parameter logic [DEPTH*WIDTH-1:0]     INIT  = '0
) (
   input  wire logic                     i_clk,
   input  wire logic                     i_rstn,
   input  wire logic                     i_we,
   input  wire logic [AW-1:0]            i_waddr,
   input  wire logic [WIDTH/8-1:0]       i_wbe,
   input  wire logic [WIDTH-1:0]         i_wdata,
   input  wire logic [AW-1:0]            i_raddr,
   output logic      [WIDTH-1:0]         o_rdata
);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [WIDTH-1:0]            rdata;
   } rsocr_mem_st_s;

   rsocr_mem_st_s st_reg;
   rsocr_mem_st_s st_next;

   always_comb begin
      st_next       = st_reg;
      st_next.rdata = st_reg.mem[i_raddr];
      for (int b = 0; b < WIDTH/8; b++) begin
         if (i_we && i_wbe[b]) begin
            st_next.mem[i_waddr][b*8 +: 8] = i_wdata[b*8 +: 8];
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         st_reg.mem   <= INIT;
         st_reg.rdata <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_rdata = st_reg.rdata;
endmodule : rsocr_cfg_mem

// file: verilog/rsocr_spi_link.sv
`timescale 1ns/1ps
module rsocr_spi_link (
   input  wire logic                     i_sclk,
   input  wire logic                     i_rstn,
   input  wire logic                     i_cs_n,
   input  wire logic                     i_mosi,
   input  wire logic [rsocr_pkg::WORD_W-1:0] i_tx_word,
   input  wire logic                     i_tx_en,
   output logic                          o_miso,
   output logic                          o_miso_oe,
   output logic [rsocr_pkg::WORD_W-1:0]  o_rx_word,
   output logic                          o_rx_toggle
);
   import rsocr_pkg::*;

   typedef struct packed {
      logic [WORD_W-2:0] shift;
      logic [WORD_W-1:0] rx_word;
      logic              toggle;
   } rsocr_link_st_s;

   rsocr_link_st_s st_reg;
   rsocr_link_st_s st_next;
   logic [3:0]     bit_cnt;
   logic           frame_rst_n;

   // Counter restarts whenever the master deselects us
   assign frame_rst_n = i_rstn & ~i_cs_n;

   always_ff @(posedge i_sclk or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         bit_cnt <= 4'h0;
      end else begin
         bit_cnt <= bit_cnt + 4'h1;
      end
   end

   // Sample on rising edge, MSB first, 16 bits per frame
   always_comb begin
      st_next       = st_reg;
      st_next.shift = {st_reg.shift[WORD_W-3:0], i_mosi};
      if (bit_cnt == 4'hF) begin
         st_next.rx_word = {st_reg.shift, i_mosi};
         st_next.toggle  = ~st_reg.toggle;
      end
   end

   always_ff @(posedge i_sclk or negedge i_rstn) begin
      if (!i_rstn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // Tx word is held still by the system side for the whole frame;
   // bit index 15-cnt moves after each rising edge, ready for the next.
   assign o_miso      = i_tx_en & i_tx_word[~bit_cnt];
   assign o_miso_oe   = ~i_cs_n & i_tx_en;
   assign o_rx_word   = st_reg.rx_word;
   assign o_rx_toggle = st_reg.toggle;
endmodule : rsocr_spi_link

// file: verilog/rsocr_regs.sv
`timescale 1ns/1ps
module rsocr_regs #(
   parameter int FLASH_CYCLES = rsocr_pkg::FLASH_BACKUP_CYCLES
) (
   input  wire logic                       i_clk,
   input  wire logic                       i_rstn,
   input  wire logic                       i_por_n,
   input  wire logic                       i_sclk,
   input  wire logic                       i_cs_n,
   input  wire logic                       i_mosi,
   output logic                            o_miso,
   output logic                            o_miso_oe,
   input  wire rsocr_pkg::rsocr_sample_s   i_sample,
   input  wire logic [rsocr_pkg::WORD_W-1:0] i_diag,
   output rsocr_pkg::rsocr_dsp_cfg_s       o_dsp_cfg,
   output logic                            o_flash_busy
);
   import rsocr_pkg::*;

   localparam int CNT_W = $clog2(FLASH_CYCLES + 1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(FLASH_CYCLES - 1);
   localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(DEPTH - 1);
   localparam int OUT_N = 5;
   localparam int O_SUP = 0;
   localparam int O_RATE = 1;
   localparam int O_EXT = 2;
   localparam int O_AUX = 3;
   localparam int O_TEMP = 4;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      rsocr_seq_e                   seq;
      logic [IDX_W-1:0]             idx;
      logic                         copy_vld;
      logic                         copy_bkp;
      logic [IDX_W-1:0]             copy_idx;
      logic [CNT_W-1:0]             wait_cnt;
      logic [2:0]                   tog_sync;
      logic                         rd_pend;
      logic [WORD_W-1:0]            tx_word;
      logic                         tx_valid;
      logic [OUT_N-1:0]             new_flag;
      logic [OUT_N-1:0][WORD_W-1:0] out_val;
      logic [BYTE_W-1:0]            cmd;
      logic [WORD_W-1:0]            decim;
      logic [WORD_W-1:0]            range;
      rsocr_dsp_cfg_s               dsp;
   } rsocr_regs_st_s;

   rsocr_regs_st_s    st_reg;
   rsocr_regs_st_s    st_next;

   logic [WORD_W-1:0] link_word;
   logic              link_toggle;
   logic [WORD_W-1:0] work_rdata;
   logic [WORD_W-1:0] flash_rdata;
   logic              w_we;
   logic [IDX_W-1:0]  w_idx;
   logic [1:0]        w_be;
   logic [WORD_W-1:0] w_data;
   logic              f_we;
   logic [IDX_W-1:0]  work_raddr;
   logic              frame_new;
   logic              err_any;
   logic [ADDR_W-1:0] fr_addr;
   logic [ADDR_W-1:0] fr_word_addr;
   logic [IDX_W-1:0]  fr_idx;

   // ----------------------------------------------------------------
   // Serial link, working copy and flash copy
   // ----------------------------------------------------------------
   rsocr_spi_link u_link (
      .i_sclk      (i_sclk),
      .i_rstn      (i_rstn),
      .i_cs_n      (i_cs_n),
      .i_mosi      (i_mosi),
      .i_tx_word   (st_reg.tx_word),
      .i_tx_en     (st_reg.tx_valid),
      .o_miso      (o_miso),
      .o_miso_oe   (o_miso_oe),
      .o_rx_word   (link_word),
      .o_rx_toggle (link_toggle)
   );

   rsocr_cfg_mem #(
      .WIDTH (WORD_W),
      .DEPTH (DEPTH),
      .AW    (IDX_W),
      .INIT  (cfg_defaults())
   ) u_work (
      .i_clk   (i_clk),
      .i_rstn  (i_rstn),
      .i_we    (w_we),
      .i_waddr (w_idx),
      .i_wbe   (w_be),
      .i_wdata (w_data),
      .i_raddr (work_raddr),
      .o_rdata (work_rdata)
   );

   // Flash copy only reloads its defaults at power-on so it survives ordinary resets
   rsocr_cfg_mem #(
      .WIDTH (WORD_W),
      .DEPTH (DEPTH),
      .AW    (IDX_W),
      .INIT  (cfg_defaults())
   ) u_flash (
      .i_clk   (i_clk),
      .i_rstn  (i_por_n),
      .i_we    (f_we),
      .i_waddr (st_reg.copy_idx),
      .i_wbe   (2'b11),
      .i_wdata (work_rdata),
      .i_raddr (st_reg.idx),
      .o_rdata (flash_rdata)
   );

   function automatic logic [WORD_W-1:0] merge(
      input logic [WORD_W-1:0] old_v,
      input logic [WORD_W-1:0] new_v,
      input logic [1:0]        be
   );
      logic [WORD_W-1:0] res;
      res = old_v;
      if (be[0]) res[BYTE_W-1:0] = new_v[BYTE_W-1:0];
      if (be[1]) res[WORD_W-1:BYTE_W] = new_v[WORD_W-1:BYTE_W];
      return res;
   endfunction : merge

   assign err_any      = |i_diag;
   assign frame_new    = st_reg.tog_sync[2] ^ st_reg.tog_sync[1];
   assign fr_addr      = link_word[13:8];
   assign fr_word_addr = {fr_addr[ADDR_W-1:1], 1'b0};
   assign fr_idx       = fr_addr[ADDR_W-1:1];

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      st_next          = st_reg;
      st_next.tog_sync = {st_reg.tog_sync[1:0], link_toggle};
      st_next.copy_vld = 1'b0;
      w_we             = 1'b0;
      w_idx            = st_reg.copy_idx;
      w_be             = 2'b11;
      w_data           = flash_rdata;
      f_we             = 1'b0;
      work_raddr       = (st_reg.seq == SEQ_BACKUP) ? st_reg.idx : fr_idx;

      // Copy sequencer: one word per cycle, data lands a cycle later
      case (st_reg.seq)
         SEQ_RESTORE: begin
            st_next.copy_vld = 1'b1;
            st_next.copy_bkp = 1'b0;
            st_next.copy_idx = st_reg.idx;
            st_next.idx      = st_reg.idx + 5'h01;
            if (st_reg.idx == IDX_LAST) begin
               st_next.seq = SEQ_IDLE;
            end
         end
         SEQ_IDLE: begin
            st_next.idx = '0;
            if (st_reg.cmd[CMD_FLASH]) begin
               st_next.seq = SEQ_BACKUP;
            end
         end
         SEQ_BACKUP: begin
            st_next.copy_vld = 1'b1;
            st_next.copy_bkp = 1'b1;
            st_next.copy_idx = st_reg.idx;
            st_next.idx      = st_reg.idx + 5'h01;
            st_next.wait_cnt = '0;
            if (st_reg.idx == IDX_LAST) begin
               st_next.seq = SEQ_SETTLE;
            end
         end
         SEQ_SETTLE: begin
            st_next.wait_cnt = st_reg.wait_cnt + 1'b1;
            if (st_reg.wait_cnt == CNT_LAST) begin
               st_next.cmd[CMD_FLASH] = 1'b0;
               st_next.seq            = SEQ_IDLE;
            end
         end
         default: begin
            st_next.seq = SEQ_IDLE;
         end
      endcase

      if (st_reg.copy_vld && FLASH_MIRROR[st_reg.copy_idx]) begin
         if (st_reg.copy_bkp) begin
            f_we = 1'b1;
         end else begin
            w_we = 1'b1;
         end
      end

      if (st_reg.rd_pend) begin
         st_next.tx_word = work_rdata;
         st_next.rd_pend = 1'b0;
      end

      // Frame decode: write byte or read request
      if (frame_new) begin
         st_next.tx_valid = ~link_word[B_WRITE];
         st_next.rd_pend  = 1'b0;
         if (link_word[B_WRITE]) begin
            if (st_reg.seq != SEQ_RESTORE) begin
               if (fr_word_addr == A_CMD) begin
                  if (!fr_addr[0]) begin
                     st_next.cmd = st_reg.cmd |
                        (link_word[BYTE_W-1:0] & CMD_IMPL_MASK);
                  end
               end else if (WRITABLE[fr_idx]) begin
                  w_we   = 1'b1;
                  w_idx  = fr_idx;
                  w_be   = fr_addr[0] ? 2'b10 : 2'b01;
                  w_data = {2{link_word[BYTE_W-1:0]}};
               end
            end
         end else begin
            st_next.tx_word = '0;
            case (fr_word_addr)
               A_SUPPLY: begin
                  st_next.tx_word = {st_reg.new_flag[O_SUP], err_any,
                     st_reg.out_val[O_SUP][B_ERR-1:0]};
                  st_next.new_flag[O_SUP] = 1'b0;
               end
               A_RATE: begin
                  st_next.tx_word = {st_reg.new_flag[O_RATE], err_any,
                     st_reg.out_val[O_RATE][B_ERR-1:0]};
                  st_next.new_flag[O_RATE] = 1'b0;
               end
               A_RATE_EXT: begin
                  st_next.tx_word = st_reg.out_val[O_EXT];
                  st_next.new_flag[O_EXT] = 1'b0;
               end
               A_AUX: begin
                  st_next.tx_word = {st_reg.new_flag[O_AUX], err_any,
                     st_reg.out_val[O_AUX][B_ERR-1:0]};
                  st_next.new_flag[O_AUX] = 1'b0;
               end
               A_TEMP: begin
                  st_next.tx_word = {st_reg.new_flag[O_TEMP], err_any,
                     st_reg.out_val[O_TEMP][B_ERR-1:0]};
                  st_next.new_flag[O_TEMP] = 1'b0;
               end
               A_DIAG: begin
                  st_next.tx_word = i_diag;
               end
               A_CMD: begin
                  st_next.tx_word = {8'h00, st_reg.cmd};
               end
               default: begin
                  st_next.rd_pend = 1'b1;
               end
            endcase
         end
      end

      // Fresh sample after the read clear, so a coincident load wins
      if (i_sample.valid) begin
         st_next.new_flag = {OUT_N{1'b1}};
         st_next.out_val[O_SUP]  = {4'h0, i_sample.supply};
         st_next.out_val[O_RATE] = {2'b00, i_sample.rate};
         st_next.out_val[O_AUX]  = {4'h0, i_sample.aux};
         st_next.out_val[O_TEMP] = {4'h0, i_sample.temp};
         st_next.out_val[O_EXT]  = i_sample.rate_ext &
            ~(FULL_MASK >> st_reg.decim[DECIM_W-1:0]);
      end

      // Shadows feed the processing chain without a memory port
      if (w_we && w_idx == A_DECIM[ADDR_W-1:1]) begin
         st_next.decim = merge(st_reg.decim, w_data, w_be);
      end
      if (w_we && w_idx == A_RANGE[ADDR_W-1:1]) begin
         st_next.range = merge(st_reg.range, w_data, w_be);
      end
      st_next.dsp.decimation  = st_reg.decim[DECIM_W-1:0];
      st_next.dsp.range_sel   = st_reg.range[10:8];
      st_next.dsp.filter_taps = st_reg.range[2:0];
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         st_reg                 <= '0;
         st_reg.seq             <= SEQ_RESTORE;
         st_reg.decim           <= DEF_DECIM;
         st_reg.range           <= DEF_RANGE;
         st_reg.dsp.decimation  <= DEF_DECIM[DECIM_W-1:0];
         st_reg.dsp.range_sel   <= DEF_RANGE[10:8];
         st_reg.dsp.filter_taps <= DEF_RANGE[2:0];
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_dsp_cfg    = st_reg.dsp;
   assign o_flash_busy = (st_reg.seq != SEQ_IDLE);
endmodule : rsocr_regs

// file: verif/rsocr_checker.sv
`timescale 1ns/1ps
module rsocr_checker #(
   parameter int FLASH_CYCLES = 50
) (
   input  wire logic i_clk,
   input  wire logic i_rstn,
   input  wire logic i_sclk,
   input  wire logic i_cs_n,
   input  wire logic i_mosi,
   input  wire logic o_miso_oe,
   input  wire logic o_flash_busy
);
   localparam int BK_MIN = FLASH_CYCLES;
   localparam int BK_MAX = FLASH_CYCLES + 48;
   // Frames are always 16 bits, so a wrapping count stays aligned
   logic [3:0] bit_reg;
   logic [1:0] rd_reg;
   always_ff @(posedge i_sclk or negedge i_rstn) begin
      if (!i_rstn) begin
         bit_reg <= 4'h0;
         rd_reg  <= 2'b00;
      end else begin
         bit_reg <= bit_reg + 4'h1;
         if (bit_reg == 4'h0) rd_reg[0] <= !i_mosi;
         if (bit_reg == 4'hF) rd_reg[1] <= rd_reg[0];
      end
   end
   sequence s_restore;
      o_flash_busy [*8] ##[1:32] !o_flash_busy;
   endsequence
   sequence s_bk_hold;
      o_flash_busy throughout (##BK_MIN 1'b1);
   endsequence
   a_oe_cs: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      $changed(o_miso_oe) && !i_cs_n |-> $past(i_cs_n))
      else $error("output enable moved inside a frame");
   a_oe_rst: assert property (
      @(posedge i_clk) disable iff (!i_rstn) $rose(i_rstn) |-> !o_miso_oe)
      else $error("output enabled after reset");
   a_oe_read: assert property (
      @(posedge i_sclk) disable iff (!i_rstn) o_miso_oe |-> rd_reg[1])
      else $error("output driven without a read request");
   a_read_oe: assert property (
      @(posedge i_sclk) disable iff (!i_rstn)
      rd_reg[1] && !i_cs_n |-> o_miso_oe)
      else $error("read answer not driven");
   a_restore_len: assert property (
      @(posedge i_clk) disable iff (!i_rstn) $rose(i_rstn) |-> s_restore)
      else $error("restore window wrong");
   a_bk_cause: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      $rose(o_flash_busy) |-> $past(i_cs_n))
      else $error("backup started inside a frame");
   a_bk_min: assert property (
      @(posedge i_clk) disable iff (!i_rstn) $rose(o_flash_busy) |-> s_bk_hold)
      else $error("backup ended too early");
   a_bk_max: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      $rose(o_flash_busy) |-> ##[BK_MIN:BK_MAX] !o_flash_busy)
      else $error("backup never ended");
endmodule : rsocr_checker
bind rsocr_regs rsocr_checker #(.FLASH_CYCLES(FLASH_CYCLES)) chk_u (
   .i_clk(i_clk), .i_rstn(i_rstn), .i_sclk(i_sclk), .i_cs_n(i_cs_n),
   .i_mosi(i_mosi), .o_miso_oe(o_miso_oe), .o_flash_busy(o_flash_busy));

// file: verif/rsocr_spi_host.sv
`timescale 1ns/1ps
module rsocr_spi_host (
   input  wire logic i_miso,
   output logic      o_sclk,
   output logic      o_cs_n,
   output logic      o_mosi
);
   initial begin
      o_sclk = 1'b1;
      o_cs_n = 1'b1;
      o_mosi = 1'b0;
   end
   // Odd start offset keeps the link unrelated in phase to i_clk
   task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
      #13;
      o_cs_n = 1'b0;
      #40;
      for (int i = 15; i >= 0; i--) begin
         o_sclk = 1'b0;
         o_mosi = tx[i];
         #40;
         rx[i]  = i_miso;
         o_sclk = 1'b1;
         #40;
      end
      o_cs_n = 1'b1;
      o_mosi = !tx[0];
      #600;
   endtask : xfer
endmodule : rsocr_spi_host

// file: verif/tb.sv
`timescale 1ns/1ps
module tb;
   import rsocr_pkg::*;
   localparam int FLASH_CYC = 50;
   logic           clk = 1'b0;
   logic           rstn = 1'b0;
   logic           por_n = 1'b0;
   wire            sclk;
   wire            cs_n;
   wire            mosi;
   wire            miso_w;
   logic           miso;
   logic           miso_oe;
   logic           busy;
   rsocr_sample_s  sample = '0;
   rsocr_sample_s  s;
   rsocr_dsp_cfg_s cfg;
   logic [15:0]    diag = 16'h0000;
   logic [15:0]    dg;
   logic [3:0]     d;
   logic           ea;
   int             bad_count = 0;
   int             cmp_count = 0;
   int             seed = 32'h3EBA;
   assign miso_w = miso_oe ? miso : 1'bz;
   always #20 clk = ~clk;
   rsocr_regs #(.FLASH_CYCLES(FLASH_CYC)) dut_u (
      .i_clk(clk), .i_rstn(rstn), .i_por_n(por_n), .i_sclk(sclk),
      .i_cs_n(cs_n), .i_mosi(mosi), .o_miso(miso), .o_miso_oe(miso_oe),
      .i_sample(sample), .i_diag(diag), .o_dsp_cfg(cfg),
      .o_flash_busy(busy));
   rsocr_spi_host host_u (.i_miso(miso_w), .o_sclk(sclk), .o_cs_n(cs_n),
      .o_mosi(mosi));
   task automatic chk(input string nm, input logic [15:0] seen,
                      input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic rchk(input string nm, input logic [5:0] a,
                       input logic [15:0] exp);
      logic [15:0] x;
      host_u.xfer({2'b00, a, 8'h00}, x);
      host_u.xfer({2'b00, A_DIAG, 8'h00}, x);
      chk(nm, x, exp);
   endtask : rchk
   task automatic wr(input logic [5:0] a, input logic [7:0] b);
      logic [15:0] x;
      host_u.xfer({2'b10, a, b}, x);
   endtask : wr
   task automatic idle();
      for (int i = 0; i < 400 && busy !== 1'b0; i++)
         @(posedge clk);
      chk("busy", {15'h0000, busy}, 16'h0000);
   endtask : idle
   task automatic rst();
      @(posedge clk);
      rstn <= 1'b0;
      repeat (16) @(posedge clk);
      por_n <= 1'b1;
      rstn  <= 1'b1;
      @(posedge clk);
      idle();
   endtask : rst
   task automatic complete_run();
      $display("TB: checks %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : complete_run
   initial begin
      #600000;
      bad_count++;
      complete_run();
   end
   initial begin
      rst();
      chk("cfg", {6'h00, cfg}, 16'h0021);
      rchk("decim", A_DECIM, DEF_DECIM);
      rchk("range", A_RANGE, DEF_RANGE);
      rchk("unmapped", 6'h08, 16'h0000);
      wr(A_RATE, 8'h55);
      for (int n = 0; n < 6; n++) begin
         d = 4'(($random(seed) & 15) % 11);
         s = rsocr_sample_s'(67'({$random(seed), $random(seed),
                                  $random(seed)}));
         s.valid = 1'b1;
         dg = n[0] ? 16'h0000 : (16'($random(seed)) | 16'h0001);
         if (n == 0) begin
            s.rate = 14'h2000;
            s.aux  = 12'hFFF;
         end
         ea = |dg;
         wr(A_DECIM, {4'h0, d});
         chk("cfg", {6'h00, cfg}, {6'h00, d, 6'h21});
         @(posedge clk);
         diag   <= dg;
         sample <= s;
         @(posedge clk);
         sample.valid <= 1'b0;
         rchk("rate", A_RATE, {1'b1, ea, s.rate});
         rchk("rate2", A_RATE, {1'b0, ea, s.rate});
         rchk("ext", A_RATE_EXT, s.rate_ext & ~(16'hFFFF >> d));
         rchk("temp", A_TEMP, {1'b1, ea, 2'b00, s.temp});
         rchk("supply", A_SUPPLY, {1'b1, ea, 2'b00, s.supply});
         rchk("aux", A_AUX, {1'b1, ea, 2'b00, s.aux});
         rchk("diag", A_DIAG, dg);
      end
      wr(6'h39, 8'h02);
      rchk("range_hi", A_RANGE, 16'h0201);
      wr(A_RANGE, 8'h04);
      rchk("range_lo", A_RANGE, 16'h0204);
      chk("cfg_r", {6'h00, cfg}, {6'h00, d, 6'h14});
      wr(A_DECIM, 8'h05);
      rst();
      rchk("unsaved", A_DECIM, DEF_DECIM);
      wr(A_DECIM, 8'h05);
      wr(A_CMD, 8'h08);
      chk("backup", {15'h0000, busy}, 16'h0001);
      idle();
      rchk("cmd", A_CMD, 16'h0000);
      rst();
      rchk("saved", A_DECIM, 16'h0005);
      complete_run();
   end
endmodule : tb
